// File: src/csd_pkg.sv
package csd_pkg;

  // ---------------------------------------------------------------
  // Register map (word addresses are byte offsets on the bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] CSD_OFF_SHUTDOWN = 8'h00;
  localparam logic [7:0] CSD_OFF_RISE_DB  = 8'h04;
  localparam logic [7:0] CSD_OFF_FALL_DB  = 8'h08;
  localparam logic [7:0] CSD_OFF_CONTROL  = 8'h0c;
  localparam logic [7:0] CSD_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] CSD_OFF_IRQ_EN   = 8'h14;
  localparam logic [7:0] CSD_OFF_IRQ_CLR  = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CSD_BIT_EVENT     = 7;
  localparam int CSD_BIT_RESTART   = 6;
  localparam int CSD_BIT_LC_EN     = 1;
  localparam int CSD_BIT_FAULT_EN  = 0;
  localparam int CSD_BIT_OUT_B_EN  = 6;
  localparam int CSD_BIT_OUT_A_EN  = 5;
  localparam int CSD_BIT_OUT_B_INV = 4;
  localparam int CSD_BIT_OUT_A_INV = 3;
  localparam int CSD_IRQ_SHUTDOWN  = 0;
  localparam int CSD_IRQ_RESTART   = 1;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int CSD_DB_W  = 6;
  localparam int CSD_IRQ_W = 2;
  localparam logic [7:0] CSD_SHUTDOWN_RST = 8'h00;
  localparam logic [7:0] CSD_CONTROL_RST  = 8'h00;
  localparam logic [CSD_DB_W-1:0] CSD_DB_ZERO = 6'h00;

  typedef enum logic [1:0] {
    CSD_EDGE_IDLE,
    CSD_EDGE_WAIT
  } csd_edge_e;

endpackage

// File: src/csd_deadband.sv
`timescale 1ns/100ps
// Delays one edge direction of a level by a programmed count; the
// opposite direction passes after one register stage.
module csd_deadband
  import csd_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                in_i,
  input  wire logic                rise_i,
  input  wire logic [CSD_DB_W-1:0] count_i,
  output logic                     out_o
);

  logic [CSD_DB_W-1:0] cnt_r;
  logic                pend_r;

  // A pending delayed edge is abandoned if the input goes back first.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_o  <= 1'b0;
      pend_r <= 1'b0;
      cnt_r  <= CSD_DB_ZERO;
    end
    else if (in_i == out_o)
    begin
      pend_r <= 1'b0;
    end
    else if ((in_i != rise_i) || (count_i == CSD_DB_ZERO))
    begin
      out_o  <= in_i;
      pend_r <= 1'b0;
    end
    else if (!pend_r)
    begin
      pend_r <= 1'b1;
      cnt_r  <= count_i - 6'h01;
    end
    else if (cnt_r == CSD_DB_ZERO)
    begin
      out_o  <= in_i;
      pend_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r - 6'h01;
    end
  end

endmodule

// File: src/csd_top.sv
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/100ps
// Behaviour
// [RULE_01] Enabled shutdown source sets event flag and forces both outputs off.
// [RULE_02] Flag zero means no event or restarted; output enables govern again.
// [RULE_03] Flag is software writable, hardware set and cleared, resets to zero.
// [RULE_04] Auto-restart bit lets hardware clear the flag once sources drop.
// [RULE_05] Logic cell output high causes shutdown only when its enable is set.
// [RULE_06] Fault pin low causes shutdown only when its enable is set.
// [RULE_07] Six-bit rising count delays rising edge by n to n+1 counts.
// [RULE_08] Six-bit falling count delays falling edge by n to n+1 counts.
// [RULE_09] A count of zero bypasses dead-band for that edge.
// [RULE_10] Dead-band counts are not cleared by reset; they keep contents.
// [RULE_11] Unused bits of shutdown and dead-band registers read as zero.
// [RULE_12] Each output has a polarity bit that inverts it when set.
// [RULE_13] Enabled shutdown sources are combined by logical OR.
module csd_top
  import csd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        wave_i,
  input  wire logic        logic_cell_output_i,
  input  wire logic        fault_input_pin_n_i,
  output logic             complementary_output_a_o,
  output logic             complementary_output_b_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic                shutdown_event_flag_r;
  logic                auto_restart_enable_r;
  logic                logic_cell_shutdown_enable_r;
  logic                fault_pin_shutdown_enable_r;
  logic [CSD_DB_W-1:0] rising_deadband_value_r;
  logic [CSD_DB_W-1:0] falling_deadband_value_r;
  logic [7:0]          control_r;
  logic [CSD_IRQ_W-1:0] irq_stat_r;
  logic [CSD_IRQ_W-1:0] irq_en_r;
  logic                shutdown_req;
  logic                wr_stb;
  logic                wr_low;
  logic                dly_a;
  logic                dly_b;
  logic                flag_set;
  logic                flag_clr_hw;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // Every access is answered in one cycle; unmapped reads return zero
  // and unmapped writes are dropped.
  assign wr_stb = cyc_i && stb_i && we_i && !ack_o;
  assign wr_low = wr_stb && sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0000_0000;
    end
    else if (cyc_i && stb_i && !we_i && !ack_o)
    begin
      dat_o <= 32'h0000_0000;
      unique case (1'b1)
        hit(adr_i, CSD_OFF_SHUTDOWN):
          dat_o[7:0] <= {shutdown_event_flag_r, auto_restart_enable_r,
                         4'h0, logic_cell_shutdown_enable_r,
                         fault_pin_shutdown_enable_r}; // RULE_11
        hit(adr_i, CSD_OFF_RISE_DB):
          dat_o[7:0] <= {2'h0, rising_deadband_value_r}; // RULE_11
        hit(adr_i, CSD_OFF_FALL_DB):
          dat_o[7:0] <= {2'h0, falling_deadband_value_r}; // RULE_11
        hit(adr_i, CSD_OFF_CONTROL):
          dat_o[7:0] <= {1'b0, control_r[6:3], 3'h0};
        hit(adr_i, CSD_OFF_IRQ_STAT):
          dat_o[CSD_IRQ_W-1:0] <= irq_stat_r;
        hit(adr_i, CSD_OFF_IRQ_EN):
          dat_o[CSD_IRQ_W-1:0] <= irq_en_r;
        default:
          dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Shutdown control
  // ---------------------------------------------------------------
  assign shutdown_req =
      (logic_cell_shutdown_enable_r && logic_cell_output_i)     // RULE_05
    | (fault_pin_shutdown_enable_r && !fault_input_pin_n_i);   // RULE_06 RULE_13

  assign flag_set    = shutdown_req;                           // RULE_01
  assign flag_clr_hw = auto_restart_enable_r && !shutdown_req &&
                       shutdown_event_flag_r;                  // RULE_04

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      auto_restart_enable_r        <= CSD_SHUTDOWN_RST[CSD_BIT_RESTART];
      logic_cell_shutdown_enable_r <= CSD_SHUTDOWN_RST[CSD_BIT_LC_EN];
      fault_pin_shutdown_enable_r  <= CSD_SHUTDOWN_RST[CSD_BIT_FAULT_EN];
    end
    else if (wr_low && hit(adr_i, CSD_OFF_SHUTDOWN))
    begin
      auto_restart_enable_r        <= dat_i[CSD_BIT_RESTART];
      logic_cell_shutdown_enable_r <= dat_i[CSD_BIT_LC_EN];
      fault_pin_shutdown_enable_r  <= dat_i[CSD_BIT_FAULT_EN];
    end
  end

  // A live shutdown request beats a software clear, so an event can
  // not be lost to a racing write.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shutdown_event_flag_r <= CSD_SHUTDOWN_RST[CSD_BIT_EVENT]; // RULE_03
    end
    else if (flag_set)
    begin
      shutdown_event_flag_r <= 1'b1;                            // RULE_01
    end
    else if (wr_low && hit(adr_i, CSD_OFF_SHUTDOWN))
    begin
      shutdown_event_flag_r <= dat_i[CSD_BIT_EVENT];            // RULE_03
    end
    else if (flag_clr_hw)
    begin
      shutdown_event_flag_r <= 1'b0;                            // RULE_04
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      control_r <= CSD_CONTROL_RST;
    end
    else if (wr_low && hit(adr_i, CSD_OFF_CONTROL))
    begin
      control_r <= dat_i[7:0];
    end
  end

  // Dead-band counts carry no reset: they keep contents across a
  // reset and are unknown only from power-up.
  always_ff @(posedge clk_i)
  begin
    if (wr_low && hit(adr_i, CSD_OFF_RISE_DB))
    begin
      rising_deadband_value_r <= dat_i[CSD_DB_W-1:0]; // RULE_10
    end
    if (wr_low && hit(adr_i, CSD_OFF_FALL_DB))
    begin
      falling_deadband_value_r <= dat_i[CSD_DB_W-1:0]; // RULE_10
    end
  end

  // ---------------------------------------------------------------
  // Dead band
  // ---------------------------------------------------------------
  // Output A follows the wave with a delayed rising edge, output B
  // follows its complement with the falling count delaying B's rise,
  // which is the falling edge of the source wave.
  csd_deadband u_db_a
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .in_i    (wave_i),
    .rise_i  (1'b1),
    .count_i (rising_deadband_value_r),  // RULE_07 RULE_09
    .out_o   (dly_a)
  );

  csd_deadband u_db_b
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .in_i    (!wave_i),
    .rise_i  (1'b1),
    .count_i (falling_deadband_value_r), // RULE_08 RULE_09
    .out_o   (dly_b)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // While the flag is set both drivers are held at their inactive
  // level, whatever the enables say; polarity applies afterwards.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      complementary_output_a_o <= 1'b0;
      complementary_output_b_o <= 1'b0;
    end
    else
    begin
      complementary_output_a_o <= (dly_a && control_r[CSD_BIT_OUT_A_EN] &&
        !shutdown_event_flag_r && !shutdown_req)        // RULE_01 RULE_02
        ^ control_r[CSD_BIT_OUT_A_INV];                 // RULE_12
      complementary_output_b_o <= (dly_b && control_r[CSD_BIT_OUT_B_EN] &&
        !shutdown_event_flag_r && !shutdown_req)        // RULE_01 RULE_02
        ^ control_r[CSD_BIT_OUT_B_INV];                 // RULE_12
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_r <= '0;
      irq_en_r   <= '0;
    end
    else
    begin
      if (wr_low && hit(adr_i, CSD_OFF_IRQ_EN))
      begin
        irq_en_r <= dat_i[CSD_IRQ_W-1:0];
      end
      irq_stat_r <= (irq_stat_r &
        ~((wr_low && hit(adr_i, CSD_OFF_IRQ_CLR)) ?
          dat_i[CSD_IRQ_W-1:0] : 2'h0))
        | {flag_clr_hw, flag_set && !shutdown_event_flag_r};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_stat_r & irq_en_r);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_shutdown_sets_flag;
    @(posedge clk_i) disable iff (rst_i)
    shutdown_req |=> shutdown_event_flag_r;
  endproperty
  a_shutdown_sets_flag: assert property (p_shutdown_sets_flag) // RULE_01
    else $error("shutdown did not set the event flag");

  property p_outputs_off;
    @(posedge clk_i) disable iff (rst_i)
    shutdown_event_flag_r |=>
      (complementary_output_a_o == $past(control_r[CSD_BIT_OUT_A_INV])) &&
      (complementary_output_b_o == $past(control_r[CSD_BIT_OUT_B_INV]));
  endproperty
  a_outputs_off: assert property (p_outputs_off) // RULE_01
    else $error("outputs active during shutdown");

  property p_no_restart;
    @(posedge clk_i) disable iff (rst_i)
    (shutdown_event_flag_r && !auto_restart_enable_r && !wr_stb)
      |=> shutdown_event_flag_r;
  endproperty
  a_no_restart: assert property (p_no_restart) // RULE_04
    else $error("flag cleared without auto-restart");

  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
    (shutdown_event_flag_r && auto_restart_enable_r && !shutdown_req &&
     !wr_stb) |=> !shutdown_event_flag_r;
  endproperty
  a_restart: assert property (p_restart) // RULE_04
    else $error("auto-restart did not clear the flag");

  property p_lc_ignored;
    @(posedge clk_i) disable iff (rst_i)
    (!logic_cell_shutdown_enable_r && !fault_pin_shutdown_enable_r)
      |-> !shutdown_req;
  endproperty
  a_lc_ignored: assert property (p_lc_ignored) // RULE_05
    else $error("disabled source caused shutdown");

  property p_fault;
    @(posedge clk_i) disable iff (rst_i)
    (fault_pin_shutdown_enable_r && !fault_input_pin_n_i) |-> shutdown_req;
  endproperty
  a_fault: assert property (p_fault) // RULE_06
    else $error("fault pin low did not request shutdown");

  property p_lc;
    @(posedge clk_i) disable iff (rst_i)
    (logic_cell_shutdown_enable_r && logic_cell_output_i) |-> shutdown_req;
  endproperty
  a_lc: assert property (p_lc) // RULE_13
    else $error("logic cell high did not request shutdown");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
    ($rose(wave_i) && rising_deadband_value_r == CSD_DB_ZERO &&
     $stable(rising_deadband_value_r)) |=> dly_a;
  endproperty
  a_bypass: assert property (p_bypass) // RULE_09
    else $error("zero dead-band still delayed the edge");

  property p_unused_zero;
    @(posedge clk_i) disable iff (rst_i)
    (ack_o && !we_i && adr_i == CSD_OFF_RISE_DB) |-> dat_o[7:6] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) // RULE_11
    else $error("unused dead-band bits read nonzero");

endmodule

// File: test/csd_switch_model.sv
`timescale 1ns/100ps
// Gate driver stage behind the two drive outputs. Its open-drain fault
// line rests at the pull-up level and is pulled low only while the bench
// commands a trip, one clock after the command, as a real driver would.
module csd_switch_model
(
  input  wire logic clk_i,
  input  wire logic trip_i,
  output logic      fault_n_o
);
  logic trip_r;

  always_ff @(posedge clk_i)
  begin
    trip_r <= trip_i;
  end

  assign fault_n_o = trip_r ? 1'b0 : 1'b1;
endmodule

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import csd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i, cyc_i, stb_i, we_i, wave_i, lc_i, trip;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  logic        ack_o, out_a, out_b, irq_o, fault_n;
  int          err_count = 0;
  int          checks = 0;
  int          seed = 63986;
  int          d;
  logic [7:0]  exp_q[$];
  logic [7:0]  adr_q[$];

  csd_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .wave_i(wave_i), .logic_cell_output_i(lc_i),
    .fault_input_pin_n_i(fault_n), .complementary_output_a_o(out_a),
    .complementary_output_b_o(out_b), .irq_o(irq_o));
  csd_switch_model drv (.clk_i(clk_i), .trip_i(trip), .fault_n_o(fault_n));

  initial forever #25 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------
  task automatic cmp_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR read %h expected %h seen %h", a, e, g);
    end
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmp_dly(input string nm, input int lo, input int hi,
                         input int g);
    checks++;
    if (g < lo || g > hi)
    begin
      err_count++;
      $display("ERROR %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Read data is judged where it appears: the single ack cycle.
  always @(negedge clk_i)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
      cmp_rd(adr_q.pop_front(), {24'h0, exp_q.pop_front()}, dat_o);
  end

  // ---------------------------------------------------------------
  // Stimulus tasks
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, v};
    // The request stands until the rising edge that samples ack high.
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    // Callers go on at mid-cycle, where the outputs have settled.
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    wb(1'b0, a, 8'h00);
  endtask

  task automatic pause(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Counts clocks from the wave change until the chosen output is high.
  task automatic wave_dly(input logic v, input logic on_b, output int k);
    @(posedge clk_i);
    wave_i <= v;
    k = 0;
    do
    begin
      @(negedge clk_i);
      k++;
    end
    while (((on_b ? out_b : out_a) !== 1'b1) && k < 100);
  endtask

  // Sampling, the dead-band stage and the output register add three
  // clocks to the n..n+1 count of dead band.
  task automatic db(input logic [7:0] n);
    wb(1'b1, CSD_OFF_RISE_DB, n);
    wb(1'b1, CSD_OFF_FALL_DB, n);
    wave_dly(1'b1, 1'b0, d);
    cmp_dly("rise delay a", n + 3, n + 4, d);
    pause(70);
    wave_dly(1'b0, 1'b1, d);
    cmp_dly("rise delay b", n + 3, n + 4, d);
    pause(70);
  endtask

  initial
  begin
    #1000000;
    err_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst_i  = 1'b1;
    cyc_i  = 1'b0;
    stb_i  = 1'b0;
    we_i   = 1'b0;
    adr_i  = 8'h00;
    sel_i  = 4'h0;
    dat_i  = 32'h0;
    wave_i = 1'b0;
    lc_i   = 1'b0;
    trip   = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CSD_OFF_SHUTDOWN, 8'h00);
    wb(1'b1, CSD_OFF_SHUTDOWN, 8'hbf);
    rd(CSD_OFF_SHUTDOWN, 8'h83);
    wb(1'b1, CSD_OFF_RISE_DB, 8'hff);
    rd(CSD_OFF_RISE_DB, 8'h3f);
    wb(1'b1, CSD_OFF_FALL_DB, 8'hff);
    rd(CSD_OFF_FALL_DB, 8'h3f);
    wb(1'b1, 8'h1c, 8'hff);
    rd(8'h1c, 8'h00);
    wb(1'b1, CSD_OFF_SHUTDOWN, 8'h00);
    wb(1'b1, CSD_OFF_CONTROL, 8'h60);
    db(8'h00);
    db(8'h01);
    db(8'h3f);
    db(8'($random(seed) & 63));
    wb(1'b1, CSD_OFF_CONTROL, 8'h78);
    pause(4);
    cmp_bit("inverted a", 1'b1, out_a);
    cmp_bit("inverted b", 1'b0, out_b);
    wb(1'b1, CSD_OFF_CONTROL, 8'h60);
    // Logic cell source asserted while its enable is still off.
    wb(1'b1, CSD_OFF_SHUTDOWN, 8'h01);
    @(posedge clk_i);
    lc_i <= 1'b1;
    pause(4);
    rd(CSD_OFF_SHUTDOWN, 8'h01);
    cmp_bit("b running", 1'b1, out_b);
    wb(1'b1, CSD_OFF_IRQ_CLR, 8'h03);
    wb(1'b1, CSD_OFF_IRQ_EN, 8'h01);
    wb(1'b1, CSD_OFF_SHUTDOWN, 8'h03);
    pause(3);
    cmp_bit("b shut", 1'b0, out_b);
    cmp_bit("irq set", 1'b1, irq_o);
    rd(CSD_OFF_SHUTDOWN, 8'h83);
    rd(CSD_OFF_IRQ_STAT, 8'h01);
    @(posedge clk_i);
    lc_i <= 1'b0;
    pause(4);
    rd(CSD_OFF_SHUTDOWN, 8'h83);
    cmp_bit("b held off", 1'b0, out_b);
    wb(1'b1, CSD_OFF_IRQ_EN, 8'h00);
    pause(2);
    cmp_bit("irq masked", 1'b0, irq_o);
    wb(1'b1, CSD_OFF_IRQ_EN, 8'h01);
    pause(2);
    cmp_bit("irq unmasked", 1'b1, irq_o);
    wb(1'b1, CSD_OFF_IRQ_CLR, 8'h01);
    pause(2);
    cmp_bit("irq cleared", 1'b0, irq_o);
    wb(1'b1, CSD_OFF_SHUTDOWN, 8'h03);
    rd(CSD_OFF_SHUTDOWN, 8'h03);
    pause(3);
    cmp_bit("b resumed", 1'b1, out_b);
    // Fault pin trip with automatic restart enabled.
    wb(1'b1, CSD_OFF_SHUTDOWN, 8'h41);
    @(posedge clk_i);
    trip <= 1'b1;
    pause(4);
    rd(CSD_OFF_SHUTDOWN, 8'hc1);
    cmp_bit("b tripped", 1'b0, out_b);
    @(posedge clk_i);
    trip <= 1'b0;
    pause(6);
    rd(CSD_OFF_SHUTDOWN, 8'h41);
    cmp_bit("b restarted", 1'b1, out_b);
    rd(CSD_OFF_IRQ_STAT, 8'h03);
    // The rising count survives a reset in mid-run; the shutdown register bits do not.
    wb(1'b1, CSD_OFF_RISE_DB, 8'h15);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CSD_OFF_RISE_DB, 8'h15);
    rd(CSD_OFF_SHUTDOWN, 8'h00);
    pause(2);
    print_verdict();
  end
endmodule
